//--- test/irs_evt_src.sv
/* Threshold event source model standing at the far side of irs_top.
   Assumes the bench clock and reset; levels follow the bench request. */
`timescale 1ns/1ps
module irs_evt_src
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_b_i,
    // Requested levels, bit 1 high event, bit 0 low event
    input  wire logic [1:0] lvl_i,
    // Threshold events
    output logic            low_irq_o,
    output logic            high_irq_o
);
    // Registered like a real comparator, so events lag the request by a cycle
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            {high_irq_o, low_irq_o} <= 2'h0;
        end
        else
        begin
            {high_irq_o, low_irq_o} <= lvl_i;
        end
    end
endmodule : irs_evt_src

//--- test/irs_top_tb_top.sv
/* Self-checking bench of irs_top: registers, routing, sample timer.
   Assumes irs_defs.svh and irs_pkg are compiled first. */
`timescale 1ns/1ps
`include "irs_defs.svh"
module irs_top_tb_top;
    import irs_pkg::*;
    logic        clock_i    = 1'b0;
    logic        rst_b_i    = 1'b0;
    logic        wr_en      = 1'b0;
    logic        rd_en      = 1'b0;
    logic [7:0]  addr       = 8'h00;
    logic [7:0]  wdata      = 8'h00;
    logic [1:0]  lvl        = 2'h0;
    irs_func_t   fn0        = 3'h0;
    irs_func_t   fn1        = 3'h0;
    logic        rd_pend    = 1'b0;
    logic [31:0] seed       = 32'hF3950512;
    logic [7:0]  rdata;
    logic        low_irq;
    logic        high_irq;
    logic        pin0;
    logic        pin1;
    logic        fe_en;
    logic        smp;
    logic [7:0]  exp_q[$];
    int          fail_count = 0;
    int          checks     = 0;
    int          rate_t[16] = `IRS_RATE_DSPS;
    int          dly_t[16]  = `IRS_DLY_NS;

    always #25 clock_i = ~clock_i;

    irs_evt_src evt (.clock_i(clock_i), .rst_b_i(rst_b_i), .lvl_i(lvl),
        .low_irq_o(low_irq), .high_irq_o(high_irq));

    irs_top uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .reg_wr_en_i(wr_en),
        .reg_rd_en_i(rd_en), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .low_threshold_irq_i(low_irq),
        .high_threshold_irq_i(high_irq), .pin0_function_sel_i(fn0),
        .pin1_function_sel_i(fn1), .pin0_irq_out_o(pin0), .pin1_irq_out_o(pin1),
        .frontend_enable_out_o(fe_en), .sample_start_o(smp));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // Called just after an edge; holds the request over one edge, so calls run back to back
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        wr_en = w;
        rd_en = !w;
        addr  = a;
        wdata = d;
        if (!w)
            exp_q.push_back(d);
        @(posedge clock_i);
        #1;
    endtask : acc

    // Releases the strobes after the last request of a burst
    task automatic idle();
        wr_en = 1'b0;
        rd_en = 1'b0;
        @(posedge clock_i);
        #1;
    endtask : idle

    // Read data stands for the cycle after the read edge; look at it mid-cycle
    always @(posedge clock_i)
        rd_pend <= rd_en & rst_b_i;

    always @(negedge clock_i)
    begin
        if (rd_pend)
            check("rdata", exp_q.pop_front(), rdata);
    end

    // Counts one sample period and the enable-high cycles within it
    task automatic meas(output int n, output int e);
        int k;
        n = 0;
        e = 0;
        k = 0;
        while (smp !== 1'b1 && k < 500)
        begin
            @(posedge clock_i);
            #1;
            k++;
        end
        do
        begin
            @(posedge clock_i);
            #1;
            n++;
            e += (fe_en === 1'b1);
        end while (smp !== 1'b1 && n < 500);
    endtask : meas

    initial
    begin
        logic [31:0] r;
        longint      p;
        longint      d;
        int          n;
        int          e;
        repeat (3) @(posedge clock_i);
        #1;
        rst_b_i = 1'b1;
        acc(0, 8'h25, 8'h21);
        acc(0, 8'h27, 8'h00);
        acc(1, 8'h25, 8'hFF);
        acc(1, 8'h26, 8'h00);
        acc(0, 8'h25, 8'h33);
        acc(0, 8'h26, 8'h00);
        r = rnd();
        acc(1, 8'h27, r[7:0]);
        acc(0, 8'h27, r[7:0]);
        idle();
        $display("test registers done");
        for (int c = 0; c < 16; c++)
        begin
            acc(1, 8'h25, {2'h0, c[3:2], 2'h0, c[1:0]});
            idle();
            for (int l = 0; l < 4; l++)
            begin
                r = rnd();
                lvl = l[1:0];
                fn0 = r[3] ? 3'h1 : r[6:4];
                fn1 = r[7] ? 3'h1 : r[10:8];
                repeat (2) @(posedge clock_i);
                #1;
                check("pin0", (fn0 == 3'h1) & |(c[1:0] & l[1:0]), pin0);
                check("pin1", (fn1 == 3'h1) & |(c[3:2] & l[1:0]), pin1);
            end
        end
        $display("test routing done");
        fn0 = 3'h1;
        fn1 = 3'h0;
        for (int c = 0; c < 8; c++)
        begin
            acc(1, 8'h27, (c < 4) ? {c[3:0], 4'h0} : {4'h3, 2'h0, c[1:0]});
            idle();
            fn0 = (c < 4) ? 3'h1 : 3'h3;
            p = longint'(`IRS_CLK_HZ) * 10 / rate_t[(c < 4) ? c : 3];
            d = (longint'(dly_t[c & 3]) * `IRS_CLK_HZ + 999999999) / 1000000000;
            meas(n, e);
            meas(n, e);
            check("period", p, n);
            check("enable", (c < 4) ? 0 : ((d < p) ? d : p), e);
        end
        $display("test timer done");
        summarize();
    end

    initial
    begin
        #(50 * 20000);
        fail_count++;
        summarize();
    end
endmodule : irs_top_tb_top

//--- verilog/irs_defs.svh
/*
 * Constants of the interrupt routing and sample timer register pair:
 * addresses, reset values, field positions, codes and timing figures.
 * Assumes it is included by bare name from files that use it.
 */
`ifndef IRS_DEFS_SVH
`define IRS_DEFS_SVH

// Register addresses and reset values
`define IRS_ADDR_ROUTE      8'h25
`define IRS_ADDR_TIMER      8'h27
`define IRS_RST_ROUTE       8'h21
`define IRS_RST_TIMER       8'h00

// Field positions
`define IRS_ROUTE1_HI       5
`define IRS_ROUTE1_LO       4
`define IRS_ROUTE0_HI       1
`define IRS_ROUTE0_LO       0
`define IRS_RATE_HI         7
`define IRS_RATE_LO         4
`define IRS_DLY_HI          3
`define IRS_DLY_LO          0

// Routing codes
`define IRS_RT_NONE         2'h0
`define IRS_RT_LOW          2'h1
`define IRS_RT_HIGH         2'h2
`define IRS_RT_EITHER       2'h3

// Pin function codes
`define IRS_FN_IRQ          3'h1
`define IRS_FN_FE_EN        3'h3

// Clock rate in Hz
`define IRS_CLK_HZ          20000000

// Sample rates in tenths of samples per second, codes 0x0 to 0xF
`define IRS_RATE_DSPS '{20000000, 10000000, 3000000, 1000000, 333000, 100000, 30000, \
    10000, 5000, 3330, 2500, 2000, 1660, 1400, 1250, 1110}

// Front-end warm-up delays in ns, codes 0x0 to 0xF
`define IRS_DLY_NS '{500, 1000, 3300, 10000, 30000, 100000, 330000, 1000000, \
    2000000, 3000000, 4000000, 5000000, 6000000, 7000000, 8000000, 9000000}

`define IRS_NS_PER_S        1000000000
`define IRS_DSPS_PER_SPS    10

`endif

//--- verilog/irs_pkg.sv
/*
 * Types shared by the interrupt routing and sample timer block.
 * Assumes irs_defs.svh supplies the numeric constants.
 */
package irs_pkg;

    typedef enum logic [1:0] {
        IRS_ST_IDLE = 2'h0,
        IRS_ST_WARM = 2'h1,
        IRS_ST_HOLD = 2'h3
    } irs_state_t;

    typedef logic [1:0] irs_route_t;
    typedef logic [2:0] irs_func_t;

endpackage : irs_pkg

//--- verilog/irs_top.sv
/*
 * Interrupt routing register and burst/autonomous sample timer with the
 * front-end enable warm-up delay.
 * Assumes the serial interface core presents byte-wide register reads
 * and writes on this clock, and that threshold interrupts and pin
 * function selectors come from logic on the same clock.
 */
// Notes on behaviour
// - Pin one routing code picks none/low/high/either
// - Pin zero routing uses the same encoding
// - Routing register at 0x25, resets to 0x21
// - Upper timer nibble selects burst sample rate
// - Lower nibble sets front-end enable to sample delay
// - Timer register at 0x27, resets to zero
// - Routed interrupt reaches pin only in interrupt function
`timescale 1ns/1ps
`include "irs_defs.svh"

module irs_top
#(
    parameter int unsigned CLK_HZ = `IRS_CLK_HZ,
    parameter int unsigned CNT_W  = 18
)
(
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_b_i,
    // Register port from the serial interface core
    input  wire logic              reg_wr_en_i,
    input  wire logic              reg_rd_en_i,
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    output logic      [7:0]        reg_rdata_o,
    // Threshold detector events
    input  wire logic              low_threshold_irq_i,
    input  wire logic              high_threshold_irq_i,
    // Pin function selectors
    input  wire irs_pkg::irs_func_t pin0_function_sel_i,
    input  wire irs_pkg::irs_func_t pin1_function_sel_i,
    // Pin-side outputs
    output logic                   pin0_irq_out_o,
    output logic                   pin1_irq_out_o,
    output logic                   frontend_enable_out_o,
    output logic                   sample_start_o
);
    import irs_pkg::*;

    localparam int unsigned RATE_DSPS [16] = `IRS_RATE_DSPS;
    localparam int unsigned DLY_NS    [16] = `IRS_DLY_NS;
    localparam logic [7:0]  RST_ROUTE      = `IRS_RST_ROUTE;
    localparam logic [7:0]  RST_TIMER      = `IRS_RST_TIMER;

    // Longest period and delay must fit the counter
    if (CLK_HZ == 0 || CNT_W < 1 || CNT_W > 31 ||
        (longint'(CLK_HZ) * `IRS_DSPS_PER_SPS / RATE_DSPS[15]) >= (longint'(1) << CNT_W) ||
        (longint'(DLY_NS[15]) * CLK_HZ / `IRS_NS_PER_S) >= (longint'(1) << CNT_W))
    begin : g_cnt_w_check
        $error("irs_top: CNT_W too small for CLK_HZ");
    end

    // Sample period rounds down, never below one cycle
    function automatic logic [CNT_W-1:0] period_cyc(input logic [3:0] code);
        longint p;
        p = longint'(CLK_HZ) * `IRS_DSPS_PER_SPS / RATE_DSPS[code];
        if (p < 1)
            p = 1;
        return CNT_W'(p);
    endfunction : period_cyc

    // Warm-up delay is a least time: round up, never below one cycle
    function automatic logic [CNT_W-1:0] delay_cyc(input logic [3:0] code);
        longint d;
        d = (longint'(DLY_NS[code]) * CLK_HZ + `IRS_NS_PER_S - 1) / `IRS_NS_PER_S;
        if (d < 1)
            d = 1;
        return CNT_W'(d);
    endfunction : delay_cyc

    typedef struct packed {
        irs_route_t       route1;
        irs_route_t       route0;
        logic [3:0]       rate;
        logic [3:0]       dly;
        irs_state_t       state;
        logic [CNT_W-1:0] pc;
        logic             en;
        logic             sample;
        logic [1:0]       pin;
        logic [7:0]       rdata;
    } irs_regs_t;

    irs_regs_t  st_ff;
    irs_regs_t  nxt_st;
    logic [1:0] routed_w;
    logic [1:0] irq_fn_w;
    logic [CNT_W-1:0] per_w;
    logic [CNT_W-1:0] dly_w;
    logic       fe_mode_w;
    logic       hold_w;

    assign per_w     = period_cyc(st_ff.rate);
    assign dly_w     = delay_cyc(st_ff.dly);
    assign fe_mode_w = (pin0_function_sel_i == `IRS_FN_FE_EN) ||
                       (pin1_function_sel_i == `IRS_FN_FE_EN);
    // A delay not shorter than the period leaves the front end powered
    assign hold_w    = (dly_w >= per_w);

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_pin
            irs_route_t code_w;
            assign code_w = (g == 0) ? st_ff.route0 : st_ff.route1;
            assign irq_fn_w[g] = ((g == 0) ? pin0_function_sel_i : pin1_function_sel_i)
                                 == `IRS_FN_IRQ;
            always_comb
            begin
                case (code_w)
                    `IRS_RT_LOW:    routed_w[g] = low_threshold_irq_i;
                    `IRS_RT_HIGH:   routed_w[g] = high_threshold_irq_i;
                    `IRS_RT_EITHER: routed_w[g] = low_threshold_irq_i | high_threshold_irq_i;
                    default:        routed_w[g] = 1'b0;
                endcase
            end
        end
    endgenerate

    always_comb
    begin
        nxt_st = st_ff;
        // Register writes
        if (reg_wr_en_i && reg_addr_i == `IRS_ADDR_ROUTE)
        begin
            nxt_st.route1 = reg_wdata_i[`IRS_ROUTE1_HI:`IRS_ROUTE1_LO];
            nxt_st.route0 = reg_wdata_i[`IRS_ROUTE0_HI:`IRS_ROUTE0_LO];
        end
        if (reg_wr_en_i && reg_addr_i == `IRS_ADDR_TIMER)
        begin
            nxt_st.rate = reg_wdata_i[`IRS_RATE_HI:`IRS_RATE_LO];
            nxt_st.dly  = reg_wdata_i[`IRS_DLY_HI:`IRS_DLY_LO];
        end
        // Register reads answer one cycle later; unmapped reads give zero
        nxt_st.rdata = 8'h00;
        if (reg_rd_en_i && reg_addr_i == `IRS_ADDR_ROUTE)
        begin
            nxt_st.rdata[`IRS_ROUTE1_HI:`IRS_ROUTE1_LO] = st_ff.route1;
            nxt_st.rdata[`IRS_ROUTE0_HI:`IRS_ROUTE0_LO] = st_ff.route0;
        end
        if (reg_rd_en_i && reg_addr_i == `IRS_ADDR_TIMER)
        begin
            nxt_st.rdata[`IRS_RATE_HI:`IRS_RATE_LO] = st_ff.rate;
            nxt_st.rdata[`IRS_DLY_HI:`IRS_DLY_LO]   = st_ff.dly;
        end
        // Pin gating by function selector
        nxt_st.pin = routed_w & irq_fn_w;
        // Sample period counter
        nxt_st.sample = (st_ff.pc == '0);
        if (st_ff.pc == '0 || st_ff.pc >= per_w)
            nxt_st.pc = per_w - CNT_W'(1);
        else
            nxt_st.pc = st_ff.pc - CNT_W'(1);
        // Front-end enable sequencing
        case (st_ff.state)
            IRS_ST_IDLE:
            begin
                if (fe_mode_w && hold_w)
                    nxt_st.state = IRS_ST_HOLD;
                else if (fe_mode_w && st_ff.pc == dly_w)
                    nxt_st.state = IRS_ST_WARM;
            end
            IRS_ST_WARM:
            begin
                if (!fe_mode_w || st_ff.pc == '0)
                    nxt_st.state = IRS_ST_IDLE;
            end
            IRS_ST_HOLD:
            begin
                if (!fe_mode_w || !hold_w)
                    nxt_st.state = IRS_ST_IDLE;
            end
            default:
                nxt_st.state = IRS_ST_IDLE;
        endcase
        nxt_st.en = (nxt_st.state != IRS_ST_IDLE);
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_ff        <= '0;
            st_ff.route1 <= RST_ROUTE[`IRS_ROUTE1_HI:`IRS_ROUTE1_LO];
            st_ff.route0 <= RST_ROUTE[`IRS_ROUTE0_HI:`IRS_ROUTE0_LO];
            st_ff.rate   <= RST_TIMER[`IRS_RATE_HI:`IRS_RATE_LO];
            st_ff.dly    <= RST_TIMER[`IRS_DLY_HI:`IRS_DLY_LO];
            st_ff.state  <= IRS_ST_IDLE;
        end
        else
            st_ff <= nxt_st;
    end

    assign reg_rdata_o           = st_ff.rdata;
    assign pin0_irq_out_o        = st_ff.pin[0];
    assign pin1_irq_out_o        = st_ff.pin[1];
    assign frontend_enable_out_o = st_ff.en;
    assign sample_start_o        = st_ff.sample;

    // Helper counters read only by assertions
    logic [CNT_W-1:0] gap_ff;
    logic [CNT_W-1:0] age_ff;
    logic             rchg_ff;
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            gap_ff  <= '0;
            age_ff  <= '0;
            rchg_ff <= 1'b0;
        end
        else
        begin
            gap_ff  <= sample_start_o ? CNT_W'(1) : gap_ff + CNT_W'(1);
            age_ff  <= frontend_enable_out_o ? age_ff + CNT_W'(1) : '0;
            // A timer write leaves the running period irregular up to the next sample
            rchg_ff <= (reg_wr_en_i && reg_addr_i == `IRS_ADDR_TIMER) ? 1'b1 :
                       (sample_start_o ? 1'b0 : rchg_ff);
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    a_pin1_either: assert property (st_ff.route1 == `IRS_RT_EITHER && irq_fn_w[1] |=>
        pin1_irq_out_o == ($past(low_threshold_irq_i) | $past(high_threshold_irq_i)))
        else $error("pin one either-routing wrong");
    a_pin0_high: assert property (st_ff.route0 == `IRS_RT_HIGH && irq_fn_w[0] |=>
        pin0_irq_out_o == $past(high_threshold_irq_i))
        else $error("pin zero high-routing wrong");
    a_route_reset: assert property ($rose(rst_b_i) |->
        st_ff.route1 == `IRS_RT_HIGH && st_ff.route0 == `IRS_RT_LOW)
        else $error("routing reset value wrong");
    a_rate_period: assert property (sample_start_o && !rchg_ff &&
        $past(sample_start_o, 2) == 1'b0 && gap_ff > CNT_W'(1) |-> gap_ff == per_w)
        else $error("sample spacing not the selected period");
    a_warm_delay: assert property ($rose(sample_start_o) && $past(frontend_enable_out_o) &&
        !hold_w && !rchg_ff |-> age_ff == dly_w)
        else $error("enable to sample delay wrong");
    a_timer_reset: assert property ($rose(rst_b_i) |->
        st_ff.rate == 4'h0 && st_ff.dly == 4'h0)
        else $error("timer reset value wrong");
    a_pin_gated: assert property (!irq_fn_w[0] |=> !pin0_irq_out_o)
        else $error("pin zero shows interrupt outside its function");
    a_rsvd_zero: assert property (reg_rd_en_i && reg_addr_i == `IRS_ADDR_ROUTE |=>
        reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[3:2] == 2'h0)
        else $error("reserved routing bits not zero");
    a_timer_wr: assert property (reg_wr_en_i && reg_addr_i == `IRS_ADDR_TIMER ##1
        reg_rd_en_i && reg_addr_i == `IRS_ADDR_TIMER |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("timer register readback wrong");

    c_sample: cover property (sample_start_o ##[1:20] sample_start_o);
    c_warm: cover property ($rose(frontend_enable_out_o) ##[1:40] sample_start_o);
    c_either: cover property (st_ff.route1 == `IRS_RT_EITHER && pin1_irq_out_o);
    c_hold: cover property (st_ff.state == IRS_ST_HOLD);

endmodule : irs_top
